// File: verilog/watchdog_ctrl.sv
// Purpose: watchdog with timed configuration changes and reset-cause flags
// Assumes: rst_n is the power-on reset; other chip resets arrive as inputs
// Notes: registers over AXI4-Lite; oscillator input sampled at core rate
//
// How it works
// - level one starts disabled; one write of enable turns it on.
// - level two keeps the timer running and enable reads one.
// - level two changes time-out only through the unlock sequence; enable ignored.
// - level two never lets the timer be disabled.
// - upper four cause bits are reserved and read zero.
// - timeout reset flag set by watchdog reset, cleared by power-on or zero write.
// - supply drop flag set by brown-out, cleared by power-on or zero write.
// - pin reset flag set by pin reset, cleared by power-on or zero write.
// - power-up flag set by power-on, cleared only by writing zero.
// - irq flag set on time-out in irq mode; cleared by vector or one write.
// - interrupt requested only with global enable and irq enable set.
// - enable and irq enable choose stopped, interrupt or reset on time-out.
// - with both set, first time-out sets the irq flag and clears irq enable; no request is raised.
// - unlock bit clears itself four cycles after being written.
// - clearing enable or changing time-out accepted only while unlocked.
// - at level one the reset flag forces enable to one.
// - time-out select gives 2K oscillator cycles doubling up to 1024K.
// - reserved time-out codes fall back to the largest valid code.
// - counter advances on a separate 128 kHz oscillator.
// - counter restarts on restart command, when disabled, and on chip reset.
// - reset-mode time-out gives a one core cycle reset pulse.
`timescale 1ns/10ps
`default_nettype none
module watchdog_ctrl #(
    parameter int BASE_TIMEOUT = wdt_pkg::BASE_TIMEOUT
) (
    input wire logic core_clk, // system clock, 40 MHz
    input wire logic rst_n, // power-on reset, synchronous
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic safety_level_select, // strap, high selects level two
    input wire logic wdt_osc, // watchdog oscillator, asynchronous
    input wire logic bor_reset_in, // brown-out reset seen, asynchronous
    input wire logic pin_reset_in, // external pin reset seen, asynchronous
    input wire logic wdt_restart, // restart instruction, one-cycle pulse
    input wire logic global_ie, // global interrupt enable of the core
    input wire logic irq_ack, // interrupt vector taken, one-cycle pulse
    output logic irq_req, // time-out interrupt request
    output logic wdt_reset_pulse, // chip reset request, one cycle
    input wire logic [11:0] s_axi_awaddr, // write address
    input wire logic [2:0] s_axi_awprot, // write protection, unused
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [11:0] s_axi_araddr, // read address
    input wire logic [2:0] s_axi_arprot, // read protection, unused
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    // synchronisers for pins from outside the core clock
    logic osc_s1, osc_s2, osc_s3;
    logic bor_s1, bor_s2, bor_s3;
    logic pin_s1, pin_s2, pin_s3;
    logic lvl_s1, lvl_s2;
    logic level2_reg;

    wdt_pkg::ctrl_type ctrl_reg, ctrl_next;
    wdt_pkg::cause_type cause_reg, cause_next;
    logic [2:0] unlock_cnt_reg;
    logic [20:0] count_reg;
    logic irq_req_reg, pulse_reg, soft_rst_reg;

    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    // no reset here: the long reset hold flushes the chains
    always_ff @(posedge core_clk) begin
        if (ce) begin
            osc_s1 <= wdt_osc;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
            bor_s1 <= bor_reset_in;
            bor_s2 <= bor_s1;
            bor_s3 <= bor_s2;
            pin_s1 <= pin_reset_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            lvl_s1 <= safety_level_select;
            lvl_s2 <= lvl_s1;
        end
    end

    // strap caught while reset is held
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            level2_reg <= lvl_s2;
        end
    end

    // bus side decoding
    wire commit = !awready_reg && !wready_reg && !bvalid_reg;
    wire hit_ctrl_w = aw_addr_reg[11:2] == wdt_pkg::CTRL_ADDR[11:2];
    wire hit_cause_w = aw_addr_reg[11:2] == wdt_pkg::CAUSE_ADDR[11:2];
    wire wr_ctrl = commit && hit_ctrl_w && w_strb_reg[0];
    wire wr_cause = commit && hit_cause_w && w_strb_reg[0];
    wire [7:0] wd = w_data_reg[7:0];
    wire ar_take = s_axi_arvalid && arready_reg;
    wire hit_ctrl_r = s_axi_araddr[11:2] == wdt_pkg::CTRL_ADDR[11:2];
    wire hit_cause_r = s_axi_araddr[11:2] == wdt_pkg::CAUSE_ADDR[11:2];

    // oscillator rising edge, seen after two flops
    wire osc_tick = osc_s2 && !osc_s3;
    wire bor_rise = bor_s2 && !bor_s3;
    wire pin_rise = pin_s2 && !pin_s3;

    // reserved codes use the largest valid one
    wire [3:0] sel_eff = (ctrl_reg.sel > wdt_pkg::SEL_MAX) ? wdt_pkg::SEL_MAX : ctrl_reg.sel;
    wire [20:0] limit = 21'(BASE_TIMEOUT) << sel_eff;
    wire running = ctrl_reg.enable || ctrl_reg.irq_en;
    wire timeout = running && osc_tick && (count_reg >= limit - 21'h1);
    wire ev_irq = timeout && ctrl_reg.irq_en;
    wire ev_rst = timeout && !ctrl_reg.irq_en && ctrl_reg.enable;
    // other chip resets reload control state, never the cause flags
    wire chip_rst = bor_rise || pin_rise || soft_rst_reg;
    // window closes after its fourth cycle
    wire unlock_end = ctrl_reg.unlock && (unlock_cnt_reg == 3'h0);

    wire [7:0] ctrl_rd = {ctrl_reg.irq_flag, ctrl_reg.irq_en, ctrl_reg.sel[3],
        ctrl_reg.unlock, ctrl_reg.enable, ctrl_reg.sel[2:0]};
    wire [7:0] cause_rd = {4'h0, cause_reg};
    wire [31:0] rd_mux = hit_ctrl_r ? {24'h0, ctrl_rd} : hit_cause_r ? {24'h0, cause_rd} : 32'h0;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next.irq_en = wd[wdt_pkg::IRQ_EN_BIT];
            if (wd[wdt_pkg::IRQ_FLAG_BIT]) begin
                ctrl_next.irq_flag = 1'b0;
            end
            // time-out change only inside the window
            if (ctrl_reg.unlock) begin
                ctrl_next.sel = {wd[wdt_pkg::SEL_HI_BIT], wd[2:0]};
            end
            if (wd[wdt_pkg::ENABLE_BIT]) begin
                ctrl_next.enable = 1'b1;
            end else if (ctrl_reg.unlock) begin
                ctrl_next.enable = 1'b0;
            end
            // window opens only with unlock and enable together
            ctrl_next.unlock = wd[wdt_pkg::UNLOCK_BIT] && wd[wdt_pkg::ENABLE_BIT];
        end else if (unlock_end) begin
            ctrl_next.unlock = 1'b0;
        end
        if (irq_ack) begin
            ctrl_next.irq_flag = 1'b0;
        end
        // set wins over vector and write clears in the same cycle; chip reset still clears it
        if (ev_irq) begin
            ctrl_next.irq_flag = 1'b1;
        end
        // irq flag first, with no request as irq enable drops; reset on the next time-out
        if (ev_irq && ctrl_reg.enable && !wr_ctrl) begin
            ctrl_next.irq_en = 1'b0;
        end
        if (chip_rst) begin
            ctrl_next = wdt_pkg::CTRL_RESET;
        end
        // level two holds enable; no disable at level two
        // reset flag keeps enable set at level one
        if (level2_reg || cause_reg.wdt) begin
            ctrl_next.enable = 1'b1;
        end
    end

    // zero write clears, events set and win
    always_comb begin
        cause_next = cause_reg;
        if (wr_cause) begin
            cause_next = cause_reg & wdt_pkg::cause_type'(wd[3:0]);
        end
        if (ev_rst) begin
            cause_next.wdt = 1'b1;
        end
        if (bor_rise) begin
            cause_next.bor = 1'b1;
        end
        if (pin_rise) begin
            cause_next.pin = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_reg <= wdt_pkg::CTRL_RESET;
            cause_reg <= wdt_pkg::CAUSE_POR_VALUE;
            unlock_cnt_reg <= 3'h0;
        end else if (ce) begin
            ctrl_reg <= ctrl_next;
            cause_reg <= cause_next;
            if (wr_ctrl && ctrl_next.unlock) begin
                unlock_cnt_reg <= wdt_pkg::UNLOCK_CYCLES - 3'h1;
            end else if (ctrl_reg.unlock && unlock_cnt_reg != 3'h0) begin
                unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
            end
        end
    end

    // level two enable applied once the strap is known
    // counter restarts on restart, stop, chip reset and time-out
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_reg <= 21'h0;
        end else if (ce) begin
            if (!running || wdt_restart || chip_rst || timeout) begin
                count_reg <= 21'h0;
            end else if (osc_tick) begin
                count_reg <= count_reg + 21'h1;
            end
        end
    end

    // request needs global and local enable
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_req_reg <= 1'b0;
            pulse_reg <= 1'b0;
            soft_rst_reg <= 1'b0;
        end else if (ce) begin
            irq_req_reg <= ctrl_reg.irq_flag && ctrl_reg.irq_en && global_ie;
            pulse_reg <= ev_rst;
            soft_rst_reg <= ev_rst;
        end
    end

    // write channel: address and data in either order, answer after both
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= wdt_pkg::RESP_OKAY;
            aw_addr_reg <= 12'h0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && awready_reg) begin
                aw_addr_reg <= s_axi_awaddr;
                awready_reg <= 1'b0;
            end
            if (s_axi_wvalid && wready_reg) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                wready_reg <= 1'b0;
            end
            if (commit) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= (hit_ctrl_w || hit_cause_w) ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
            end
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // read channel: one read at a time, data one cycle after the address
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= wdt_pkg::RESP_OKAY;
            rdata_reg <= 32'h0;
        end else if (ce) begin
            if (ar_take) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_mux;
                rresp_reg <= (hit_ctrl_r || hit_cause_r) ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    assign irq_req = irq_req_reg;
    assign wdt_reset_pulse = pulse_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence open_write_s;
        ce && wr_ctrl && wd[wdt_pkg::UNLOCK_BIT] && wd[wdt_pkg::ENABLE_BIT];
    endsequence

    sequence four_ce_s;
        ce [*4];
    endsequence

    // reset time-out: pulse and flag, then a reload
    sequence reset_timeout_s;
        ce && ev_rst;
    endsequence

    a_level2_enable: assert property (level2_reg && $past(rst_n) |-> ctrl_reg.enable)
        else $error("enable dropped at level two");
    a_window_closes: assert property (open_write_s ##1 four_ce_s |=> !ctrl_reg.unlock)
        else $error("unlock bit outlived its window");
    a_window_holds: assert property (open_write_s ##1 (ce && !chip_rst && !wr_ctrl) [*3] |-> ctrl_reg.unlock)
        else $error("unlock bit closed early");
    a_pulse_single: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
        else $error("reset pulse longer than one cycle");
    a_pulse_flag: assert property (wdt_reset_pulse |-> cause_reg.wdt || $past(wr_cause))
        else $error("reset pulse without its flag");
    a_irq_gate: assert property ($rose(irq_req) |-> $past(ctrl_reg.irq_en && ctrl_reg.irq_flag && global_ie))
        else $error("interrupt request without enables");
    a_cause_reserved: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && (!$past(hit_cause_r && ar_take) || s_axi_rdata[7:4] == 4'h0))
        else $error("reserved cause bits nonzero");
    a_sel_locked: assert property (ce && !ctrl_reg.unlock && !chip_rst |=> $stable(ctrl_reg.sel))
        else $error("time-out changed while locked");
    a_disable_locked: assert property (ce && ctrl_reg.enable && !ctrl_reg.unlock && !chip_rst |=> ctrl_reg.enable)
        else $error("enable cleared while locked");
    a_flag_forces: assert property (ce && !level2_reg && cause_reg.wdt |=> ctrl_reg.enable)
        else $error("reset flag did not force enable");
    a_sel_clamp: assert property (sel_eff <= wdt_pkg::SEL_MAX)
        else $error("reserved time-out code used");
    a_stopped_idle: assert property (ce && !running |=> count_reg == 21'h0)
        else $error("counter ran while stopped");
    a_irq_first: assert property (ce && ev_irq && ctrl_reg.enable && !wr_ctrl && !chip_rst |=> ctrl_reg.irq_flag && !ctrl_reg.irq_en)
        else $error("combined mode did not clear irq enable");

    a_reset_action: assert property (reset_timeout_s |=> wdt_reset_pulse && cause_reg.wdt)
        else $error("reset time-out lacks pulse or flag");
    a_reset_reload: assert property (reset_timeout_s ##1 ce |=> count_reg == 21'h0 && ctrl_reg.enable)
        else $error("chip reset did not restart timer");
    a_irq_flag_set: assert property (ce && ev_irq && !chip_rst |=> ctrl_reg.irq_flag)
        else $error("irq flag not set");
    a_level1_start: assert property (!level2_reg && !$past(rst_n) |-> !ctrl_reg.enable)
        else $error("level one not disabled at start");
    a_wdt_clear: assert property (ce && wr_cause && !wd[wdt_pkg::WDT_FLAG_BIT] && !ev_rst |=> !cause_reg.wdt)
        else $error("reset flag kept after zero write");
    a_por_clear: assert property (ce && wr_cause && !wd[wdt_pkg::POR_FLAG_BIT] |=> !cause_reg.por)
        else $error("power-up flag kept after zero write");
endmodule : watchdog_ctrl
`default_nettype wire

// File: verilog/wdt_pkg.sv
// Purpose: shared constants and types for the watchdog control block
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: register indices are word indices; byte address is index times four
package wdt_pkg;
    // register word indices and byte addresses
    localparam logic [7:0] CTRL_INDEX = 8'h21;
    localparam logic [7:0] CAUSE_INDEX = 8'h22;
    localparam logic [11:0] CTRL_ADDR = {2'b00, CTRL_INDEX, 2'b00};
    localparam logic [11:0] CAUSE_ADDR = {2'b00, CAUSE_INDEX, 2'b00};

    // control register bit positions
    localparam int IRQ_FLAG_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int SEL_HI_BIT = 5;
    localparam int UNLOCK_BIT = 4;
    localparam int ENABLE_BIT = 3;

    // cause register bit positions
    localparam int WDT_FLAG_BIT = 3;
    localparam int BOR_FLAG_BIT = 2;
    localparam int PIN_FLAG_BIT = 1;
    localparam int POR_FLAG_BIT = 0;

    // change window length in core clock cycles
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    // highest legal time-out code
    localparam logic [3:0] SEL_MAX = 4'h9;
    // watchdog oscillator cycles for code zero
    localparam int BASE_TIMEOUT = 2048;
    localparam int OSC_HZ = 128000;
    localparam int CORE_HZ = 40000000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic irq_flag;
        logic irq_en;
        logic [3:0] sel;
        logic unlock;
        logic enable;
    } ctrl_type;

    typedef struct packed {
        logic wdt;
        logic bor;
        logic pin;
        logic por;
    } cause_type;

    localparam ctrl_type CTRL_RESET = '{default: 1'b0};
    localparam cause_type CAUSE_POR_VALUE = '{wdt: 1'b0, bor: 1'b0, pin: 1'b0, por: 1'b1};
endpackage : wdt_pkg

// File: testbench/wdt_core_model.sv
// Purpose: stand-in for the core side and the watchdog oscillator
// Assumes: oscillator runs free at 128 kHz, unrelated in phase to core_clk
// Notes: takes the interrupt vector one cycle after a request, when allowed
`timescale 1ns/10ps
`default_nettype none
module wdt_core_model (
    input wire logic core_clk, // system clock
    input wire logic irq_req, // interrupt request from the block
    input wire logic ack_on, // bench lets the core take the vector
    output var logic wdt_osc, // watchdog oscillator
    output var logic irq_ack, // vector taken, one cycle
    output var int osc_edges // oscillator rising edges so far
);
    initial begin
        wdt_osc = 1'b0;
        osc_edges = 0;
        forever begin
            #3906.25 wdt_osc = ~wdt_osc;
            if (wdt_osc)
                osc_edges++;
        end
    end

    initial irq_ack = 1'b0;
    // vector entry clears flag
    // two pulses per request, since the request lags the flag by a cycle
    always @(posedge core_clk)
        irq_ack <= irq_req && ack_on && !irq_ack;
endmodule : wdt_core_model
`default_nettype wire

// File: testbench/watchdog_timed_config_reset_flags_bench.sv
// Purpose: self-checking bench for the watchdog control block
// Assumes: BASE_TIMEOUT shortened to 4, so code n times out after 4 << n oscillator edges
// Notes: the strap is changed only across a full power-on reset
`timescale 1ns/10ps
`default_nettype none
module watchdog_timed_config_reset_flags_bench;
    logic core_clk, rst_n = 1'b0, safety_level_select = 1'b0, bor_reset_in = 1'b0, pin_reset_in = 1'b0;
    logic wdt_restart = 1'b0, global_ie = 1'b0, ack_on = 1'b0, ce = 1'b1, wdt_osc, irq_ack, irq_req, wdt_reset_pulse;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int osc_edges, n_fail = 0, samples_checked = 0, n_pulse = 0;
    localparam logic [11:0] ctrl_a = wdt_pkg::CTRL_ADDR;
    localparam logic [11:0] cause_a = wdt_pkg::CAUSE_ADDR;

    watchdog_ctrl #(.BASE_TIMEOUT(4)) DUT (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
        .safety_level_select(safety_level_select), .wdt_osc(wdt_osc), .bor_reset_in(bor_reset_in),
        .pin_reset_in(pin_reset_in), .wdt_restart(wdt_restart), .global_ie(global_ie), .irq_ack(irq_ack),
        .irq_req(irq_req), .wdt_reset_pulse(wdt_reset_pulse), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    wdt_core_model model (.core_clk(core_clk), .irq_req(irq_req), .ack_on(ack_on), .wdt_osc(wdt_osc),
        .irq_ack(irq_ack), .osc_edges(osc_edges));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // counts reset pulses so quiet stretches can be checked afterwards
    always @(posedge core_clk)
        if (wdt_reset_pulse === 1'b1)
            n_pulse <= n_pulse + 1;

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] resp = wdt_pkg::RESP_OKAY);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
                break;
        end
        chk({31'h0, n < 50}, 32'h1, "write answer");
        if (n >= 50)
            print_verdict();
        chk({30'h0, s_axi_bresp}, {30'h0, resp}, "write response");
    endtask : wr

    task automatic rdr(input logic [11:0] a, input logic [7:0] exp, input string what,
                       input logic [1:0] resp = wdt_pkg::RESP_OKAY);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
                break;
        end
        chk({31'h0, n < 50}, 32'h1, "read answer");
        if (n >= 50)
            print_verdict();
        chk({30'h0, s_axi_rresp}, {30'h0, resp}, what);
        if (resp == wdt_pkg::RESP_OKAY)
            chk(s_axi_rdata, {24'h000000, exp}, what);
    endtask : rdr

    // pulse selects the reset output, otherwise the interrupt request
    task automatic wait_hi(input logic pulse, input int bound, input logic hit, input string what);
        int n;
        for (n = 0; n < bound; n++) begin
            @(posedge core_clk);
            if ((pulse ? wdt_reset_pulse : irq_req) === 1'b1)
                break;
        end
        chk({31'h0, n < bound}, {31'h0, hit}, what);
        if (hit && n >= bound)
            print_verdict();
    endtask : wait_hi

    task automatic restart();
        wdt_restart <= 1'b1;
        @(posedge core_clk);
        wdt_restart <= 1'b0;
    endtask : restart

    task automatic power_on(input logic level);
        rst_n <= 1'b0;
        safety_level_select <= level;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
    endtask : power_on

    initial begin
        int p;
        int e;
        power_on(1'b0);
        rdr(ctrl_a, 8'h00, "ctrl after reset");
        rdr(cause_a, 8'h01, "cause after reset");
        wr(cause_a, 8'hff);
        rdr(cause_a, 8'h01, "ones keep flags");
        wr(cause_a, 8'h00);
        rdr(cause_a, 8'h00, "power-up flag cleared");
        wr(12'h000, 8'h08, wdt_pkg::RESP_SLVERR);
        rdr(12'h000, 8'h00, "unmapped read", wdt_pkg::RESP_SLVERR);
        $display("test registers done");
        s_axi_wstrb <= 4'h0;
        wr(ctrl_a, 8'h08);
        s_axi_wstrb <= 4'hf;
        rdr(ctrl_a, 8'h00, "lane off write");
        wr(ctrl_a, 8'h08);
        rdr(ctrl_a, 8'h08, "enabled");
        wr(ctrl_a, 8'h01);
        rdr(ctrl_a, 8'h08, "locked write");
        wr(ctrl_a, 8'h18);
        rdr(ctrl_a, 8'h18, "window open");
        repeat (4) @(posedge core_clk);
        rdr(ctrl_a, 8'h08, "window shut");
        wr(ctrl_a, 8'h18);
        wr(ctrl_a, 8'h00);
        rdr(ctrl_a, 8'h00, "disabled");
        $display("test change window done");
        wr(ctrl_a, 8'h08);
        wait_hi(1'b1, 5000, 1'b1, "reset time-out");
        @(posedge core_clk);
        chk({31'h0, wdt_reset_pulse}, 32'h0, "pulse one cycle");
        rdr(cause_a, 8'h08, "timeout reset flag");
        wr(ctrl_a, 8'h18);
        wr(ctrl_a, 8'h00);
        rdr(ctrl_a, 8'h08, "flag holds enable");
        wr(cause_a, 8'h00);
        rdr(cause_a, 8'h00, "timeout flag cleared");
        wr(ctrl_a, 8'h18);
        wr(ctrl_a, 8'h00);
        rdr(ctrl_a, 8'h00, "turned off");
        wait_hi(1'b1, 3000, 1'b0, "stopped timer");
        $display("test reset mode done");
        p = n_pulse;
        global_ie <= 1'b1;
        ack_on <= 1'b1;
        wr(ctrl_a, 8'h40);
        wait_hi(1'b0, 5000, 1'b1, "interrupt time-out");
        repeat (4) @(posedge core_clk);
        chk({31'h0, irq_req}, 32'h0, "vector taken");
        rdr(ctrl_a, 8'h40, "flag cleared by vector");
        ack_on <= 1'b0;
        global_ie <= 1'b0;
        repeat (1500) @(posedge core_clk);
        chk({31'h0, irq_req}, 32'h0, "masked request");
        rdr(ctrl_a, 8'hc0, "flag pending");
        global_ie <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk({31'h0, irq_req}, 32'h1, "unmasked request");
        wr(ctrl_a, 8'hc0);
        rdr(ctrl_a, 8'h40, "flag write one");
        chk(n_pulse, p, "no reset in interrupt mode");
        restart();
        wr(ctrl_a, 8'hc8);
        repeat (1800) @(posedge core_clk);
        rdr(ctrl_a, 8'h88, "irq enable dropped");
        chk(n_pulse, p, "interrupt before reset");
        wait_hi(1'b1, 5000, 1'b1, "second time-out resets");
        $display("test interrupt mode done");
        bor_reset_in <= 1'b1;
        repeat (4) @(posedge core_clk);
        bor_reset_in <= 1'b0;
        pin_reset_in <= 1'b1;
        repeat (4) @(posedge core_clk);
        pin_reset_in <= 1'b0;
        repeat (4) @(posedge core_clk);
        rdr(cause_a, 8'h0e, "reset causes");
        wr(cause_a, 8'h0b);
        rdr(cause_a, 8'h0a, "supply drop cleared");
        wr(cause_a, 8'h00);
        rdr(cause_a, 8'h00, "all cleared");
        p = n_pulse;
        repeat (20) begin
            restart();
            repeat (200) @(posedge core_clk);
        end
        chk(n_pulse, p, "restart holds off");
        ce <= 1'b0;
        repeat (3000) @(posedge core_clk);
        chk(n_pulse, p, "frozen timer");
        ce <= 1'b1;
        $display("test reset causes done");
        power_on(1'b1);
        rdr(ctrl_a, 8'h08, "level two enabled");
        rdr(cause_a, 8'h01, "power-up flag set");
        wr(ctrl_a, 8'h18);
        wr(ctrl_a, 8'h00);
        rdr(ctrl_a, 8'h08, "cannot disable");
        wr(ctrl_a, 8'h01);
        rdr(ctrl_a, 8'h08, "select locked");
        wr(ctrl_a, 8'h18);
        wr(ctrl_a, 8'h01);
        rdr(ctrl_a, 8'h09, "select changed");
        restart();
        e = osc_edges;
        wait_hi(1'b1, 8000, 1'b1, "code one time-out");
        e = osc_edges - e;
        chk({31'h0, e >= 6 && e <= 9}, 32'h1, "code one length");
        $display("test level two done");
        print_verdict();
    end
endmodule : watchdog_timed_config_reset_flags_bench
`default_nettype wire
